// file: rtl/tops_core.sv
// test output select, pll bypass and wishbone status port
`timescale 1ns/1ps
module tops_core
  import tops_pkg::*;
(
  input wire logic SYS_CLK, // 10 MHz system clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic SER_CLK, // serial configuration clock
  input wire logic SER_DATA, // serial configuration data
  input wire logic SER_LATCH, // serial latch strobe
  input wire logic PAR_LOAD, // parallel load strobe
  input wire logic [8:0] PAR_M, // parallel feedback divide value
  input wire logic [1:0] PAR_N, // parallel post divide code
  input wire logic XTAL_CLK, // crystal reference level
  input wire logic VCO_CLK, // pll vco level
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic [3:0] WB_ADR_I, // wishbone byte address
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  output logic [31:0] WB_DAT_O, // wishbone read data
  output logic WB_ACK_O, // wishbone acknowledge
  output logic TEST_OUT, // diagnostic test pin
  output logic FOUT_P, // synthesized clock, true
  output logic FOUT_N // synthesized clock, complement
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tops_cfg_t cfg, next_cfg;
  logic [TOPS_SR_W-1:0] shift, next_shift;
  logic sclk_q, latch_q, xtal_q, vco_q;
  logic [2:0] post_cnt, next_post_cnt;
  logic [9:0] fb_cnt, next_fb_cnt;
  logic [TOPS_REF_DIV_W-1:0] ref_cnt, next_ref_cnt;
  logic [1:0] out4_cnt, next_out4_cnt;
  logic fout, next_fout;
  logic next_test;
  logic test_en, next_test_en;
  logic [31:0] next_dat;
  logic next_ack;

  logic sclk_rise, latch_fall, xtal_rise, vco_rise;
  logic bypass, src_rise, src_lvl, fb_out;
  logic [9:0] fb_limit;
  logic [3:0] ratio;

  assign sclk_rise = SER_CLK && !sclk_q;
  assign latch_fall = !SER_LATCH && latch_q;
  assign xtal_rise = XTAL_CLK && !xtal_q;
  assign vco_rise = VCO_CLK && !vco_q;
  assign bypass = (cfg.t == TOPS_T_BYPASS);
  assign src_rise = bypass ? sclk_rise : vco_rise;
  assign src_lvl = bypass ? SER_CLK : VCO_CLK;
  assign fb_out = (fb_cnt == 10'h000); // one-count pulse

  always_comb begin
    case (cfg.n)
      TOPS_N_DIV2: ratio = 4'h2;
      TOPS_N_DIV4: ratio = 4'h4;
      TOPS_N_DIV8: ratio = 4'h8;
      default: ratio = 4'h1;
    endcase
  end

  // bypass period is twice the post ratio
  assign fb_limit = bypass ? {5'h00, ratio, 1'b0} :
                    ((cfg.m == 9'h000) ? 10'h001 : {1'b0, cfg.m});

  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_shift = shift;
    if (!PAR_LOAD) begin
      // transparent parallel latch; test field held at default
      next_cfg.t = TOPS_T_SHIFT;
      next_cfg.n = PAR_N;
      next_cfg.m = PAR_M;
    end else begin
      if (sclk_rise) begin
        // first bit ends in the top: t2 first
        next_shift = {shift[TOPS_SR_W-2:0], SER_DATA};
      end
      if (latch_fall) begin
        next_cfg = tops_cfg_t'(shift);
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg <= TOPS_CFG_RST;
      shift <= TOPS_SR_RST;
    end else begin
      cfg <= next_cfg;
      shift <= next_shift;
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  always_comb begin
    next_post_cnt = post_cnt;
    next_fb_cnt = fb_cnt;
    next_ref_cnt = ref_cnt;
    next_out4_cnt = out4_cnt;
    case (cfg.n)
      TOPS_N_DIV2: next_fout = post_cnt[0];
      TOPS_N_DIV4: next_fout = post_cnt[1];
      TOPS_N_DIV8: next_fout = post_cnt[2];
      default: next_fout = src_lvl;
    endcase
    if (src_rise) begin
      next_post_cnt = post_cnt + 3'h1;
      if (fb_cnt + 10'h001 >= fb_limit) begin
        next_fb_cnt = 10'h000;
      end else begin
        next_fb_cnt = fb_cnt + 10'h001;
      end
    end
    // a new setting restarts the feedback count, so no stale count
    // from a longer period survives into bypass
    if (next_cfg != cfg) begin
      next_fb_cnt = 10'h000;
    end
    if (xtal_rise) begin
      next_ref_cnt = ref_cnt + 4'h1;
    end
    if (next_fout && !fout) begin
      next_out4_cnt = out4_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // test multiplexer
  // ---------------------------------------------------------------
  always_comb begin
    case (cfg.t)
      TOPS_T_SHIFT: next_test = shift[TOPS_SR_W-1];
      TOPS_T_ONE: next_test = 1'b1;
      TOPS_T_REF16: next_test = ref_cnt[TOPS_REF_DIV_W-1];
      TOPS_T_FB: next_test = fb_out;
      TOPS_T_OUT: next_test = fout;
      TOPS_T_ZERO: next_test = 1'b0;
      TOPS_T_BYPASS: next_test = fb_out;
      TOPS_T_OUT4: next_test = out4_cnt[1];
      default: next_test = 1'b0;
    endcase
    if (!test_en) begin
      next_test = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  always_comb begin
    next_test_en = test_en;
    next_dat = WB_DAT_O;
    next_ack = 1'b0;
    if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
      next_ack = 1'b1;
      next_dat = 32'h0000_0000;
      case (WB_ADR_I)
        TOPS_ADDR_STATUS:
          next_dat = {17'h00000, bypass, cfg.t, cfg.n, cfg.m};
        TOPS_ADDR_CTRL: begin
          next_dat = {31'h0000_0000, test_en};
          if (WB_WE_I && WB_SEL_I[0]) begin
            next_test_en = WB_DAT_I[TOPS_CTRL_TEST_EN];
          end
        end
        TOPS_ADDR_SHIFT: next_dat = {18'h00000, shift};
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sclk_q <= 1'b0;
      latch_q <= 1'b0;
      xtal_q <= 1'b0;
      vco_q <= 1'b0;
      post_cnt <= 3'h0;
      fb_cnt <= 10'h000;
      ref_cnt <= 4'h0;
      out4_cnt <= 2'h0;
      fout <= 1'b0;
      test_en <= TOPS_TEST_EN_RST;
      TEST_OUT <= 1'b0;
      FOUT_P <= 1'b0;
      FOUT_N <= 1'b1;
      WB_DAT_O <= 32'h0000_0000;
      WB_ACK_O <= 1'b0;
    end else begin
      sclk_q <= SER_CLK;
      latch_q <= SER_LATCH;
      xtal_q <= XTAL_CLK;
      vco_q <= VCO_CLK;
      post_cnt <= next_post_cnt;
      fb_cnt <= next_fb_cnt;
      ref_cnt <= next_ref_cnt;
      out4_cnt <= next_out4_cnt;
      fout <= next_fout;
      test_en <= next_test_en;
      TEST_OUT <= next_test;
      FOUT_P <= next_fout;
      FOUT_N <= !next_fout;
      WB_DAT_O <= next_dat;
      WB_ACK_O <= next_ack;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_load_low_clears;
    !PAR_LOAD |=> cfg.t == TOPS_T_SHIFT;
  endproperty
  a_load_low_clears: assert property (p_load_low_clears)
    else $error("test field not cleared while load low");

  property p_latch_moves;
    PAR_LOAD && latch_fall |=> cfg == tops_cfg_t'($past(shift));
  endproperty
  a_latch_moves: assert property (p_latch_moves)
    else $error("latch did not transfer shift register");

  property p_hold_select;
    PAR_LOAD && !latch_fall |=> $stable(cfg.t);
  endproperty
  a_hold_select: assert property (p_hold_select)
    else $error("test field changed without latch");

  property p_shift_in;
    PAR_LOAD && sclk_rise |=>
      shift == {$past(shift[TOPS_SR_W-2:0]), $past(SER_DATA)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not shifted in");

  sequence s_const_sel(logic [2:0] code);
    test_en && cfg.t == code;
  endsequence

  property p_one;
    s_const_sel(TOPS_T_ONE) |=> TEST_OUT;
  endproperty
  a_one: assert property (p_one)
    else $error("code 001 did not give one");

  property p_zero;
    s_const_sel(TOPS_T_ZERO) |=> !TEST_OUT;
  endproperty
  a_zero: assert property (p_zero)
    else $error("code 101 did not give zero");

  property p_shift_view;
    s_const_sel(TOPS_T_SHIFT) |=> TEST_OUT == $past(shift[TOPS_SR_W-1]);
  endproperty
  a_shift_view: assert property (p_shift_view)
    else $error("test pin does not show shift register");

  property p_bypass_src;
    bypass && sclk_rise |=> post_cnt == $past(post_cnt) + 3'h1;
  endproperty
  a_bypass_src: assert property (p_bypass_src)
    else $error("bypass post divider not stepped by serial clock");

  property p_bypass_fb_period;
    bypass && $stable(cfg) |-> fb_cnt < {5'h00, ratio, 1'b0};
  endproperty
  a_bypass_fb_period: assert property (p_bypass_fb_period)
    else $error("bypass feedback count exceeds twice ratio");

  property p_fout_pair;
    FOUT_P != FOUT_N;
  endproperty
  a_fout_pair: assert property (p_fout_pair)
    else $error("output pair not complementary");

  property p_par_no_select;
    !$stable(cfg.t) |->
      cfg.t == TOPS_T_SHIFT || ($past(PAR_LOAD) && $past(latch_fall));
  endproperty
  a_par_no_select: assert property (p_par_no_select)
    else $error("test field changed by parallel path");

  property p_bypass_pin;
    bypass && test_en |=> TEST_OUT == $past(fb_out);
  endproperty
  a_bypass_pin: assert property (p_bypass_pin)
    else $error("bypass test pin not fed by feedback counter");

  property p_fb_view;
    s_const_sel(TOPS_T_FB) |=> TEST_OUT == $past(fb_out);
  endproperty
  a_fb_view: assert property (p_fb_view)
    else $error("code 011 does not show feedback counter");

endmodule

// file: rtl/tops_pkg.sv
// constants and types for the test output select and pll bypass block
// Behaviour
// - exactly one internal node drives the test pin, chosen by test field; the code forces the pin to 0 while test_en is low
// - parallel inputs never change the test-select field
// - parallel load strobe low forces the test field to 000
// - code 110 feeds serial clock into feedback counter and post divider
// - in bypass, output clock is post divider, test pin is feedback counter
// - decode 000 shift,001 one,010 ref/16,011 fb,100 out,101 zero,110,111
// - shift register view shifts out at the serial clock rate
// - bypass feedback output rate is serial clock over twice post ratio
// - feedback counter view on test pin need not be 50% duty
// - stream order test, post, feedback bits, each msb first
// - falling edge of latch strobe moves shift register into settings
package tops_pkg;

  // ---------------------------------------------------------------
  // configuration layout
  // ---------------------------------------------------------------
  localparam int TOPS_T_W = 3;
  localparam int TOPS_N_W = 2;
  localparam int TOPS_M_W = 9;
  localparam int TOPS_SR_W = TOPS_T_W + TOPS_N_W + TOPS_M_W;

  typedef struct packed {
    logic [TOPS_T_W-1:0] t;
    logic [TOPS_N_W-1:0] n;
    logic [TOPS_M_W-1:0] m;
  } tops_cfg_t;

  // ---------------------------------------------------------------
  // test-select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] TOPS_T_SHIFT = 3'h0;
  localparam logic [2:0] TOPS_T_ONE = 3'h1;
  localparam logic [2:0] TOPS_T_REF16 = 3'h2;
  localparam logic [2:0] TOPS_T_FB = 3'h3;
  localparam logic [2:0] TOPS_T_OUT = 3'h4;
  localparam logic [2:0] TOPS_T_ZERO = 3'h5;
  localparam logic [2:0] TOPS_T_BYPASS = 3'h6;
  localparam logic [2:0] TOPS_T_OUT4 = 3'h7;

  // post divide codes
  localparam logic [1:0] TOPS_N_DIV2 = 2'h0;
  localparam logic [1:0] TOPS_N_DIV4 = 2'h1;
  localparam logic [1:0] TOPS_N_DIV8 = 2'h2;
  localparam logic [1:0] TOPS_N_DIV1 = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam tops_cfg_t TOPS_CFG_RST = '0;
  localparam logic [TOPS_SR_W-1:0] TOPS_SR_RST = 14'h0000;
  localparam logic TOPS_TEST_EN_RST = 1'b1;

  // ---------------------------------------------------------------
  // wishbone map
  // ---------------------------------------------------------------
  localparam logic [3:0] TOPS_ADDR_STATUS = 4'h0;
  localparam logic [3:0] TOPS_ADDR_CTRL = 4'h4;
  localparam logic [3:0] TOPS_ADDR_SHIFT = 4'h8;
  localparam int TOPS_CTRL_TEST_EN = 0;
  localparam int TOPS_STAT_BYPASS = 14;

  // reference divide used on the ref/16 view
  localparam int TOPS_REF_DIV_W = 4;

endpackage

// file: testbench/tops_ctrl_model.sv
// controller model driving the serial and parallel config pins
`timescale 1ns/1ps
module tops_ctrl_model
  import tops_pkg::*;
(
  input wire logic clk, // system clock
  output logic sclk, // serial clock
  output logic sdat, // serial data
  output logic slat, // serial latch strobe
  output logic pload, // parallel load strobe
  output logic [8:0] pm, // parallel feedback value
  output logic [1:0] pn // parallel post code
);
  initial begin
    {sclk, sdat, slat, pload, pm, pn} = '0;
  end
  // ---------------------------------------------------------------
  // pin tasks
  // ---------------------------------------------------------------
  // four cycle period, far below the input ceiling; idle low
  task automatic tick();
    @(posedge clk);
    sclk <= 1'b1;
    repeat (2) @(posedge clk);
    sclk <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulses(input int k);
    repeat (k) tick();
  endtask
  task automatic shift(input logic [TOPS_SR_W-1:0] s);
    for (int i = TOPS_SR_W - 1; i >= 0; i--) begin
      @(posedge clk);
      sdat <= s[i];
      tick();
    end
    // data line no longer holds the last bit after the frame
    sdat <= ~s[0];
  endtask
  task automatic latch();
    @(posedge clk);
    slat <= 1'b1;
    repeat (2) @(posedge clk);
    slat <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_par(input logic l, input logic [8:0] m,
      input logic [1:0] n);
    @(posedge clk);
    pload <= l;
    pm <= m;
    pn <= n;
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the test output select block
`timescale 1ns/1ps
module tb_top;
  import tops_pkg::*;
  logic clk, rst_n, sclk, sdat, slat, pload, xtal, vco, cyc, stb, we, ack;
  logic test_out, fout_p, fout_n, cnt_en, t_prev, f_prev;
  logic [8:0] pm;
  logic [1:0] pn;
  logic [3:0] adr, sel;
  logic [31:0] dat_w, dat_r, q;
  logic [13:0] s;
  tops_cfg_t c;
  int bad_count, n_compared, t_rise, f_rise, r;
  tops_core tops_core_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .SER_CLK(sclk), .SER_DATA(sdat),
    .SER_LATCH(slat), .PAR_LOAD(pload), .PAR_M(pm), .PAR_N(pn),
    .XTAL_CLK(xtal), .VCO_CLK(vco), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_ACK_O(ack), .TEST_OUT(test_out),
    .FOUT_P(fout_p), .FOUT_N(fout_n)
  );
  tops_ctrl_model tops_ctrl_model_inst (
    .clk(clk), .sclk(sclk), .sdat(sdat), .slat(slat), .pload(pload),
    .pm(pm), .pn(pn)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // references toggle each cycle; rising edges counted for rate checks
  always @(posedge clk) begin
    xtal <= ~xtal;
    vco <= ~vco;
    t_prev <= test_out;
    f_prev <= fout_p;
    if (cnt_en && test_out === 1'b1 && t_prev === 1'b0) t_rise++;
    if (cnt_en && fout_p === 1'b1 && f_prev === 1'b0) f_rise++;
  end
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    chk(nm, e, (g >= e - 1 && g <= e + 1) ? e : g);
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat_w} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_r;
    if (n >= 40) begin
      bad_count++;
      $display("[ERR] wb ack expected 1 seen 0");
    end
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
      input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic load(input tops_cfg_t v);
    tops_ctrl_model_inst.shift(v);
    tops_ctrl_model_inst.latch();
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] st(input tops_cfg_t v);
    return {17'h0, v.t == TOPS_T_BYPASS, v.t, v.n, v.m};
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog expected done seen timeout");
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {cyc, stb, we, adr, dat_w, xtal, vco, cnt_en, rst_n} = '0;
    sel = 4'hf;
    void'($urandom(32'h6fd7));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("test_out rst", 0, test_out);
    rd(TOPS_ADDR_CTRL, 32'h1, "ctrl rst");
    rd(TOPS_ADDR_STATUS, 32'h0, "status rst");
    tops_ctrl_model_inst.set_par(1'b1, 9'h000, 2'h0);
    for (int i = 0; i < 8; i++) begin
      c = tops_cfg_t'(14'($urandom));
      c.t = i[2:0];
      if (i == 3) c.m = 9'(2 + $urandom % 14);
      r = c.n == TOPS_N_DIV1 ? 1 : 2 << c.n;
      load(c);
      rd(TOPS_ADDR_STATUS, st(c), "status");
      rd(TOPS_ADDR_SHIFT, 32'(c), "shift reg");
      t_rise = 0;
      f_rise = 0;
      cnt_en <= 1'b1;
      if (c.t == TOPS_T_BYPASS) tops_ctrl_model_inst.pulses(64);
      else repeat (320) @(posedge clk);
      cnt_en <= 1'b0;
      @(posedge clk);
      chk("fout pair", 1, fout_p ^ fout_n);
      case (c.t)
        TOPS_T_ONE: chk("one", 1, test_out);
        TOPS_T_ZERO: chk("zero", 0, test_out);
        TOPS_T_FB: near("fb view", 160 / c.m, t_rise);
        TOPS_T_REF16: near("ref16", 10, t_rise);
        TOPS_T_OUT: near("out view", 160 / r, t_rise);
        TOPS_T_OUT4: near("out4", 40 / r, t_rise);
        TOPS_T_BYPASS: begin
          near("bypass fb", 32 / r, t_rise);
          near("bypass out", 64 / r, f_rise);
        end
        default: ;
      endcase
      $display("code %0d done", i);
    end
    c.t = TOPS_T_ONE;
    load(c);
    s = {3'h0, 11'($urandom)};
    tops_ctrl_model_inst.shift(s);
    chk("held sel", 1, test_out);
    rd(TOPS_ADDR_STATUS, st(c), "held cfg");
    tops_ctrl_model_inst.latch();
    repeat (3) @(posedge clk);
    chk("shift view", 0, test_out);
    s = {1'b1, 13'($urandom)};
    tops_ctrl_model_inst.shift(s);
    repeat (2) @(posedge clk);
    chk("shift view", 1, test_out);
    $display("latch test done");
    wb(1'b1, TOPS_ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("test off", 0, test_out);
    rd(TOPS_ADDR_CTRL, 32'h0, "ctrl");
    wb(1'b1, TOPS_ADDR_CTRL, 32'h1);
    wb(1'b1, 4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0, "unmapped");
    rd(TOPS_ADDR_CTRL, 32'h1, "ctrl");
    $display("bus test done");
    c.t = TOPS_T_BYPASS;
    load(c);
    s = c;
    c = tops_cfg_t'(14'($urandom));
    c.t = TOPS_T_SHIFT;
    tops_ctrl_model_inst.set_par(1'b0, c.m, c.n);
    tops_ctrl_model_inst.shift(~s);
    rd(TOPS_ADDR_STATUS, st(c), "par low");
    rd(TOPS_ADDR_SHIFT, 32'(s), "refused shift");
    tops_ctrl_model_inst.set_par(1'b1, c.m, c.n);
    repeat (3) @(posedge clk);
    rd(TOPS_ADDR_STATUS, st(c), "par high");
    $display("parallel test done");
    complete_run();
  end
endmodule
